// *** scp_serial_port.v ***
// Summary of operation
// RL1: Transmit state code 0 to 14 reported
// RL2: Receive state code 0 to 12 reported
// RL3: FIFO counts 11 bits, split low and high
// RL4: Status shows internal line levels
// RL5: Clock select 1 bus clock, 0 reference tick
// RL6: Each line has its own inversion control
// RL7: FIFO reset bits empty each FIFO
// RL8: Infrared encoding, start, inversions, loop mode
// RL9: Infrared 11th bit copies 10th or zero
// RL10: Loopback feeds transmit into receive
// RL11: Break zeros sent after transmission completes
// RL12: Stop length one, one and half or two
// RL13: Data length codes give 5 to 8 bits
// RL14: Parity added and checked, even or odd
// RL15: Receive timeout after programmed idle bits
// RL16: Request-to-send drops above flow threshold
// RL17: Transmit empty event below empty threshold
// RL18: Receive full event above full threshold
// RL19: Minimum pulse widths and edge count recorded
// RL20: Xon/Xoff request self-clears as its char starts to send
// RL21: Auto Xon/Xoff by thresholds, optional stripping
// RL22: Frame end on idle; gap between transmissions
// RL23: Masked status is raw AND enable; write-one clears; bits 0 and 1 follow the FIFO levels and do not clear
// RL24: Software releases FIFO reset bits afterwards
`include "scp_regs.vh"
`default_nettype none
module scp_serial_port #(
    parameter DLOG = 4
) (
    // Clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // AXI4-Lite slave
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Serial line
    input  wire        refTick,
    input  wire        rxd,
    input  wire        cts,
    input  wire        dsr,
    output reg         txd,
    output reg         rts,
    output reg         dtr
);
    localparam D = 1 << DLOG;
    localparam [DLOG:0] PTR0 = {(DLOG+1){1'b0}};
    reg  [31:0] conf0, conf1, swfc, idleR, evtEna;
    reg  [8:0]  thrHi;
    reg  [9:0]  wakeR;
    reg  [5:0]  flowR;
    reg  [15:0] div;
    reg  [`SCP_EVT_W-1:0] evtStk;
    reg         awHave, wHave;
    reg  [7:0]  awA;
    reg  [31:0] wD;
    reg  [3:0]  wS;
    reg  [31:0] rdMux;
    reg         rdOk;
    // Synchronisers
    reg  [3:0]  s1, s2, s3, lvl, lvlD;
    wire        wrEn = awHave && wHave && !s_axi_bvalid;
    wire        rdEn = s_axi_arvalid && s_axi_arready;
    wire        parOdd = conf0[`SCP_C0_PAR];
    wire        parEn = conf0[`SCP_C0_PAREN];
    wire [1:0]  bitNum = conf0[`SCP_C0_BITS+1:`SCP_C0_BITS];
    wire [1:0]  stopNum = conf0[`SCP_C0_STOP+1:`SCP_C0_STOP];
    wire        irdaEn = conf0[`SCP_C0_IREN];
    wire        swFlow = flowR[0];
    wire        srcTick = conf0[`SCP_C0_CLKSEL] | (lvl[3] & ~lvlD[3]); // [RL5]
    wire [16:0] fullLen = {div, 1'b0};
    wire [16:0] halfLen = {1'b0, div};
    wire [7:0]  mask = 8'hFF >> (2'd3 - bitNum); // [RL13]
    // Transmit FIFO
    reg  [7:0]  txMem [0:D-1];
    reg  [DLOG:0] txWp, txRp;
    wire [DLOG:0] txCnt = txWp - txRp;
    wire [10:0] txCnt11 = {{(10 - DLOG){1'b0}}, txCnt}; // [RL3]
    // Receive FIFO
    reg  [7:0]  rxMem [0:D-1];
    reg  [DLOG:0] rxWp, rxRp;
    wire [DLOG:0] rxCnt = rxWp - rxRp;
    wire [10:0] rxCnt11 = {{(10 - DLOG){1'b0}}, rxCnt}; // [RL3]
    wire        txPush = wrEn && awA == `SCP_FIFO_DATA && wS[0] && txCnt != D[DLOG:0];
    wire        rxPop = rdEn && s_axi_araddr == `SCP_FIFO_DATA && rxCnt != 0;
    // Thresholds
    wire [10:0] fullThr = {1'b0, thrHi[5:3], conf1[6:0]};
    wire [10:0] emptyThr = {1'b0, thrHi[8:6], conf1[14:8]};
    wire [10:0] flowThr = {1'b0, thrHi[2:0], conf1[22:16]}; // [RL16]
    wire        rxFullLvl = rxCnt11 > fullThr; // [RL18]
    wire        txEmptyLvl = txCnt11 < emptyThr; // [RL17]
    // Transmitter state
    reg  [3:0]  txState;
    reg  [16:0] txTmr;
    reg  [9:0]  txBits;
    reg  [7:0]  txShift;
    reg         txPar, lastBit, wasData, xoffSent, swStopped;
    reg         lineTx;
    wire [16:0] txLen = (txState == 4'd12 && stopNum == 2'd2) ? halfLen : fullLen; // [RL12]
    wire        txEnd = srcTick && txTmr == txLen - 17'd1;
    wire        ctsIn = lvl[1] ^ conf0[`SCP_C0_CTSINV]; // [RL6]
    wire        ctsOk = !conf0[`SCP_C0_TXFLOW] || ctsIn;
    wire        txAllow = flowR[3] ? 1'b1 : flowR[2] ? 1'b0 : (ctsOk && !swStopped);
    wire        wantXoff = flowR[5] || (swFlow && !xoffSent && rxCnt11 > {3'b0, swfc[15:8]}); // [RL21]
    wire        wantXon = flowR[4] || (swFlow && xoffSent && rxCnt11 < {3'b0, swfc[7:0]}); // [RL21]
    wire        txIdle = txState == 4'd0;
    wire        sendXoff = txIdle && wantXoff;
    wire        sendXon = txIdle && !wantXoff && wantXon;
    wire        sendData = txIdle && !wantXoff && !wantXon && txCnt != 0 && txAllow;
    wire        frameEnd = txEnd && (txState == 4'd12 || (txState == 4'd11 && stopNum == 2'd1));
    wire        brkNow = frameEnd && conf0[`SCP_C0_TXBRK] && wasData && txCnt == 0 && idleR[27:20] != 0;
    wire        brkDone = txEnd && txState == 4'd13 && txBits == {2'b0, idleR[27:20]} - 10'd1;
    wire        irdaOut = conf0[`SCP_C0_IRTXEN] && !lineTx && txTmr < halfLen; // [RL8]
    wire        txLine = (irdaEn ? irdaOut ^ conf0[`SCP_C0_IRTXINV] : lineTx) ^ conf0[`SCP_C0_TXINV];
    // Receiver state
    reg  [3:0]  rxState;
    reg  [16:0] rxTmr, idleTmr;
    reg  [7:0]  rxShift;
    reg  [9:0]  idleBits;
    reg  [16:0] irHold;
    reg         parErr, frmErr;
    wire        rxPin = lvl[2] ^ conf0[`SCP_C0_RXINV]; // [RL6]
    wire        irSrc = (conf0[`SCP_C0_IRLOOP] ? irdaOut : rxPin) ^ conf0[`SCP_C0_IRRXINV]; // [RL8]
    wire        irLine = !irSrc && irHold == 0;
    wire        rxIn = conf0[`SCP_C0_LOOP] ? lineTx : (irdaEn ? irLine : rxPin); // [RL10]
    wire [16:0] rxLen = (rxState == 4'd1) ? halfLen : fullLen;
    wire        rxEnd = srcTick && rxTmr == rxLen - 17'd1;
    wire        rxDone = rxEnd && (rxState == 4'd12 || (rxState == 4'd11 && stopNum == 2'd1));
    wire [7:0]  rxData = rxShift >> (2'd3 - bitNum);
    wire        isFlowCh = swFlow && (rxData == swfc[23:16] || rxData == swfc[31:24]);
    wire        rxKeep = !(isFlowCh && flowR[1]); // [RL21]
    wire        rxPush = rxDone && rxKeep && rxCnt != D[DLOG:0];
    wire        idleTick = srcTick && idleTmr == fullLen - 17'd1;
    // Autobaud
    reg  [19:0] edgeTmr, lowMin, highMin;
    reg  [9:0]  edgeCnt;
    wire        rxEdge = lvl[2] != lvlD[2];
    // Events
    wire [`SCP_EVT_W-1:0] evtSet = {
        idleTick && idleBits == idleR[9:0] && rxState == 4'd0, // [RL22]
        brkDone,
        sendXoff,
        sendXon,
        conf1[31] && idleTick && idleBits == {3'b0, conf1[30:24]} && rxCnt != 0, // [RL15]
        rxDone && rxKeep && rxCnt == D[DLOG:0],
        rxDone && frmErr,
        rxDone && parErr,
        1'b0, 1'b0};
    wire [`SCP_EVT_W-1:0] evtRaw = {evtStk[`SCP_EVT_W-1:2], txEmptyLvl, rxFullLvl};

    function [31:0] merge(input [31:0] o, input [31:0] n, input [3:0] s);
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction
    wire [31:0] divW  = merge({16'h0, div}, wD, wS);
    wire [31:0] flowW = merge({26'h0, flowR}, wD, wS);
    wire [31:0] wakeW = merge({22'h0, wakeR}, wD, wS);
    wire [31:0] thrW  = merge({23'h0, thrHi}, wD, wS);

    always @* begin
        rdOk = 1'b1;
        case (s_axi_araddr)
            `SCP_FIFO_DATA:  rdMux = {24'h0, rxMem[rxRp[DLOG-1:0]]};
            `SCP_EVT_RAW:    rdMux = {22'h0, evtRaw};
            `SCP_EVT_ST:     rdMux = {22'h0, evtRaw & evtEna[`SCP_EVT_W-1:0]}; // [RL23]
            `SCP_EVT_ENA:    rdMux = evtEna;
            `SCP_EVT_CLR:    rdMux = 32'h0;
            `SCP_BAUD_DIV:   rdMux = {16'h0, div};
            `SCP_STATUS:     rdMux = {txState, dtr, rts, txd, 1'b0, txCnt11[7:0], rxState,
                                     1'b0, lvl[0] ^ conf0[`SCP_C0_DSRINV], ctsIn, rxPin, rxCnt11[7:0]}; // [RL1] [RL2] [RL4]
            `SCP_CONF0:      rdMux = conf0;
            `SCP_CONF1:      rdMux = conf1;
            `SCP_LOW_PULSE:  rdMux = {12'h0, lowMin}; // [RL19]
            `SCP_HIGH_PULSE: rdMux = {12'h0, highMin}; // [RL19]
            `SCP_EDGE_CNT:   rdMux = {22'h0, edgeCnt}; // [RL19]
            `SCP_FLOW:       rdMux = {26'h0, flowR};
            `SCP_WAKE:       rdMux = {22'h0, wakeR};
            `SCP_SWFC:       rdMux = swfc;
            `SCP_IDLE:       rdMux = idleR;
            `SCP_THR_HIGH:   rdMux = {23'h0, thrHi};
            `SCP_MEM_CNT:    rdMux = {26'h0, rxCnt11[10:8], txCnt11[10:8]}; // [RL3]
            default: begin
                rdMux = 32'h0;
                rdOk = 1'b0;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= 2'b00;
            s_axi_rdata <= 32'h0;
            awHave <= 1'b0;
            wHave <= 1'b0;
            awA <= 8'h0;
            wD <= 32'h0;
            wS <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave <= 1'b1;
                awA <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave <= 1'b1;
                wD <= s_axi_wdata;
                wS <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrEn) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awA[7:2] <= 6'h10 || awA == `SCP_THR_HIGH || awA == `SCP_MEM_CNT)
                               && awA[1:0] == 2'b00 ? 2'b00 : 2'b10;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                awHave <= 1'b0;
                wHave <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (rdEn) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdMux;
                s_axi_rresp <= rdOk ? 2'b00 : 2'b10;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Registers and FIFOs
    always @(posedge clk) begin
        if (!rst_n) begin
            conf0 <= `SCP_CONF0_RST;
            conf1 <= 32'h0;
            swfc <= 32'h0;
            idleR <= 32'h0;
            evtEna <= 32'h0;
            thrHi <= 9'h0;
            wakeR <= 10'h0;
            flowR <= 6'h0;
            div <= `SCP_DIV_RST;
            evtStk <= {`SCP_EVT_W{1'b0}};
            txWp <= PTR0;
            txRp <= PTR0;
            rxWp <= PTR0;
            rxRp <= PTR0;
            s1 <= 4'h7;
            s2 <= 4'h7;
            s3 <= 4'h7;
            lvl <= 4'h7;
            lvlD <= 4'h7;
        end else begin
            s1 <= {refTick, rxd, cts, dsr};
            s2 <= s1;
            s3 <= s2;
            lvl <= (s2 & s3) | (lvl & (s2 ^ s3));
            lvlD <= lvl;
            flowR <= flowR & ~{sendXoff, sendXon, 4'h0}; // [RL20]
            evtStk <= (evtStk & ~((wrEn && awA == `SCP_EVT_CLR) ? wD[`SCP_EVT_W-1:0] : 10'h0)) | evtSet; // [RL23]
            if (wrEn) begin
                case (awA)
                    `SCP_EVT_ENA:  evtEna <= merge(evtEna, wD, wS);
                    `SCP_BAUD_DIV: div <= divW[15:0];
                    `SCP_CONF0:    conf0 <= merge(conf0, wD, wS);
                    `SCP_CONF1:    conf1 <= merge(conf1, wD, wS);
                    `SCP_FLOW:     flowR <= flowW[5:0];
                    `SCP_WAKE:     wakeR <= wakeW[9:0];
                    `SCP_SWFC:     swfc <= merge(swfc, wD, wS);
                    `SCP_IDLE:     idleR <= merge(idleR, wD, wS);
                    `SCP_THR_HIGH: thrHi <= thrW[8:0];
                    default: ;
                endcase
            end
            if (txPush) begin
                txMem[txWp[DLOG-1:0]] <= wD[7:0];
                txWp <= txWp + 1'b1;
            end
            if (sendData)
                txRp <= txRp + 1'b1;
            if (rxPush) begin
                rxMem[rxWp[DLOG-1:0]] <= rxData;
                rxWp <= rxWp + 1'b1;
            end
            if (rxPop)
                rxRp <= rxRp + 1'b1;
            if (conf0[`SCP_C0_TXRST]) begin // [RL7] [RL24]
                txWp <= PTR0;
                txRp <= PTR0;
            end
            if (conf0[`SCP_C0_RXRST]) begin // [RL7] [RL24]
                rxWp <= PTR0;
                rxRp <= PTR0;
            end
        end
    end

    always @* begin
        case (txState)
            4'd0:  lineTx = 1'b1;
            4'd1:  lineTx = 1'b0;
            4'd10: lineTx = txPar;
            4'd11: lineTx = irdaEn ? (conf0[`SCP_C0_IRWCTL] & lastBit) : 1'b1; // [RL9]
            4'd13: lineTx = 1'b0; // [RL11]
            default: lineTx = (txState <= 4'd9) ? txShift[0] : 1'b1;
        endcase
    end

    // Transmitter
    always @(posedge clk) begin
        if (!rst_n) begin
            txState <= 4'd0;
            txTmr <= 17'h0;
            txBits <= 10'h0;
            txShift <= 8'h0;
            txPar <= 1'b0;
            lastBit <= 1'b1;
            wasData <= 1'b0;
            xoffSent <= 1'b0;
            txd <= 1'b1;
            rts <= 1'b0;
            dtr <= 1'b0;
        end else begin
            txd <= txLine;
            rts <= (conf1[23] ? !(rxCnt11 > flowThr) : conf0[`SCP_C0_SWRTS]) ^ conf0[`SCP_C0_RTSINV]; // [RL16] [RL6]
            dtr <= conf0[`SCP_C0_SWDTR] ^ conf0[`SCP_C0_DTRINV]; // [RL6]
            txTmr <= (txIdle || txEnd) ? 17'h0 : (srcTick ? txTmr + 17'd1 : txTmr);
            if (txIdle && (sendXoff || sendXon || sendData)) begin
                txShift <= (sendXoff ? swfc[31:24] : sendXon ? swfc[23:16] : txMem[txRp[DLOG-1:0]]) & mask;
                txPar <= ^((sendXoff ? swfc[31:24] : sendXon ? swfc[23:16] : txMem[txRp[DLOG-1:0]]) & mask)
                         ^ parOdd; // [RL14]
                wasData <= sendData;
                txState <= 4'd1; // [RL20]
                if (sendXoff)
                    xoffSent <= 1'b1;
                else if (sendXon)
                    xoffSent <= 1'b0;
            end else if (txEnd) begin
                lastBit <= lineTx;
                txBits <= txBits + 10'd1;
                if (txState >= 4'd2 && txState <= 4'd9) begin
                    txShift <= {1'b0, txShift[7:1]};
                    txState <= (txState == {2'b0, bitNum} + 4'd6) ? (parEn ? 4'd10 : 4'd11) : txState + 4'd1;
                end else if (frameEnd || brkDone) begin
                    txBits <= 10'h0;
                    txState <= brkNow ? 4'd13 : (idleR[19:10] != 0 ? 4'd14 : 4'd0); // [RL11] [RL22]
                end else if (txState == 4'd11) begin
                    txState <= 4'd12; // [RL12]
                end else if (txState == 4'd14) begin
                    if (txBits == idleR[19:10] - 10'd1)
                        txState <= 4'd0; // [RL22]
                end else if (txState != 4'd13) begin
                    txState <= txState + 4'd1;
                    txBits <= 10'h0;
                end
            end
        end
    end

    // Receiver and autobaud
    always @(posedge clk) begin
        if (!rst_n) begin
            rxState <= 4'd0;
            rxTmr <= 17'h0;
            rxShift <= 8'h0;
            parErr <= 1'b0;
            frmErr <= 1'b0;
            swStopped <= 1'b0;
            idleTmr <= 17'h0;
            idleBits <= 10'h0;
            irHold <= 17'h0;
            edgeTmr <= 20'h0;
            lowMin <= 20'hFFFFF;
            highMin <= 20'hFFFFF;
            edgeCnt <= 10'h0;
        end else begin
            irHold <= !irSrc ? fullLen : (irHold != 0 ? irHold - 17'd1 : 17'h0);
            rxTmr <= (rxState == 4'd0 || rxEnd) ? 17'h0 : (srcTick ? rxTmr + 17'd1 : rxTmr);
            if (rxState == 4'd0) begin
                idleTmr <= idleTick ? 17'h0 : (srcTick ? idleTmr + 17'd1 : idleTmr);
                if (idleTick && idleBits != 10'h3FF)
                    idleBits <= idleBits + 10'd1;
                if (!rxIn) begin
                    rxState <= 4'd1;
                    rxShift <= 8'h0;
                    parErr <= 1'b0;
                    frmErr <= 1'b0;
                end
            end else begin
                idleTmr <= 17'h0;
                idleBits <= 10'h0;
            end
            if (rxEnd) begin
                if (rxState == 4'd1)
                    rxState <= rxIn ? 4'd0 : 4'd2;
                else if (rxState >= 4'd2 && rxState <= 4'd9) begin
                    rxShift <= {rxIn, rxShift[7:1]};
                    rxState <= (rxState == {2'b0, bitNum} + 4'd6) ? (parEn ? 4'd10 : 4'd11) : rxState + 4'd1;
                end else if (rxState == 4'd10) begin
                    parErr <= rxIn != (^rxShift ^ parOdd); // [RL14]
                    rxState <= 4'd11;
                end else if (rxState == 4'd11 && stopNum != 2'd1) begin
                    frmErr <= !rxIn;
                    rxState <= 4'd12;
                end else
                    rxState <= 4'd0;
                if (rxState == 4'd11 && stopNum == 2'd1)
                    frmErr <= !rxIn;
            end
            if (rxDone && isFlowCh) // [RL21]
                swStopped <= rxData == swfc[31:24];
            edgeTmr <= rxEdge ? 20'h1 : (edgeTmr != 20'hFFFFF ? edgeTmr + 20'd1 : edgeTmr);
            if (rxEdge) begin // [RL19]
                edgeCnt <= edgeCnt + 10'd1;
                if (!lvlD[2] && edgeTmr < lowMin)
                    lowMin <= edgeTmr;
                if (lvlD[2] && edgeTmr < highMin)
                    highMin <= edgeTmr;
            end
        end
    end
endmodule
`default_nettype wire

// *** scp_regs.vh ***
`ifndef SCP_REGS_VH
`define SCP_REGS_VH
`define SCP_FIFO_DATA   8'h00
`define SCP_EVT_RAW     8'h04
`define SCP_EVT_ST      8'h08
`define SCP_EVT_ENA     8'h0C
`define SCP_EVT_CLR     8'h10
`define SCP_BAUD_DIV    8'h14
`define SCP_STATUS      8'h1C
`define SCP_CONF0       8'h20
`define SCP_CONF1       8'h24
`define SCP_LOW_PULSE   8'h28
`define SCP_HIGH_PULSE  8'h2C
`define SCP_EDGE_CNT    8'h30
`define SCP_FLOW        8'h34
`define SCP_WAKE        8'h38
`define SCP_SWFC        8'h3C
`define SCP_IDLE        8'h40
`define SCP_THR_HIGH    8'h58
`define SCP_MEM_CNT     8'h64
`define SCP_CONF0_RST   32'h0800001C
`define SCP_DIV_RST     16'h0010
`define SCP_C0_PAR      0
`define SCP_C0_PAREN    1
`define SCP_C0_BITS     2
`define SCP_C0_STOP     4
`define SCP_C0_SWRTS    6
`define SCP_C0_SWDTR    7
`define SCP_C0_TXBRK    8
`define SCP_C0_IRLOOP   9
`define SCP_C0_IRTXEN   10
`define SCP_C0_IRWCTL   11
`define SCP_C0_IRTXINV  12
`define SCP_C0_IRRXINV  13
`define SCP_C0_LOOP     14
`define SCP_C0_TXFLOW   15
`define SCP_C0_IREN     16
`define SCP_C0_RXRST    17
`define SCP_C0_TXRST    18
`define SCP_C0_RXINV    19
`define SCP_C0_CTSINV   20
`define SCP_C0_DSRINV   21
`define SCP_C0_TXINV    22
`define SCP_C0_RTSINV   23
`define SCP_C0_DTRINV   24
`define SCP_C0_CLKSEL   27
`define SCP_EVT_W       10
`endif

// *** scp_serial_port_props.sv ***
`default_nettype none
module scp_props (
    // Clock and reset
    input wire logic        clk, rst_n,
    // Bus handshakes and answers
    input wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
    input wire logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
    input wire logic        s_axi_rvalid, s_axi_rready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input wire logic [31:0] s_axi_rdata,
    // Serial output
    input wire logic        txd
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sWrTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence sRdTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    AST_WRITE_ANSWER: assert property (sWrTaken |=> ##1 s_axi_bvalid)
        else $error("write answer missing");
    AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped");
    AST_WRITE_BLOCKED: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    AST_WRITE_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
        else $error("write answer not released");
    AST_READ_ANSWER: assert property (sRdTaken |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer missing");
    AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed");
    AST_READ_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
        else $error("read answer not released");
    AST_UNMAPPED: assert property (sRdTaken ##0 (s_axi_araddr == 8'h18) |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    AST_RESET_STATE: assert property (disable iff (1'b0) !rst_n |=> !s_axi_bvalid && !s_axi_rvalid && txd)
        else $error("reset state wrong");
endmodule
bind scp_serial_port scp_props u_scp_props (.*);
`default_nettype wire

// *** scp_line_partner.sv ***
`default_nettype none
module scp_line_partner #(
    parameter int BitClks = 8
) (
    // Clock
    input wire logic clk,
    // Line
    input wire logic txd,
    output var logic rxd, cts, dsr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] lastByte, sh;
    initial begin
        {rxd, cts, dsr} = 3'h7;
        lastByte = 8'h00;
    end
    task automatic sendFrame(input logic [7:0] d, input logic flip);
        logic [10:0] f;
        f = {1'b1, ^d ^ flip, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (BitClks) @(posedge clk);
        end
    endtask
    always begin
        @(negedge txd);
        repeat (BitClks / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BitClks) @(posedge clk);
            sh[i] = txd;
        end
        lastByte = sh;
    end
endmodule
`default_nettype wire

// *** test_serial_port_config_status.sv ***
`default_nettype none
`define CHK(nm, exp, got) begin checkCount++; if ((got) !== (exp)) begin badCount++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
module test_serial_port_config_status;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, refTick, rxd, cts, dsr, txd, rts, dtr;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    int          badCount = 0, checkCount = 0;
    scp_serial_port u_scp_serial_port (.*);
    scp_line_partner u_scp_line_partner (.*);
    task automatic completeRun;
        $display("Checks %0d mismatches %0d", checkCount, badCount);
        if (badCount == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic stuck(input int n);
        if (n >= 300) begin
            badCount++;
            $display("ERROR bus answer expected 1 seen 0");
            completeRun();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w, b = 0;
        int n = 0;
        @(posedge clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        while (!b && n < 300) begin
            @(negedge clk);
            {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            @(posedge clk);
            n++;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        stuck(n);
    endtask
    task automatic rdw(input logic [7:0] a);
        logic ar, r = 0;
        int n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        while (!r && n < 300) begin
            @(negedge clk);
            {ar, r, rd, rr} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge clk);
            n++;
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        stuck(n);
    endtask
    task automatic look(input string nm, input logic [7:0] a, input logic [31:0] m, e);
        int n = 0;
        do begin
            rdw(a);
            n++;
        end while ((rd & m) !== e && n < 200);
        `CHK(nm, e, rd & m)
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {rst_n, refTick, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hF};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        look("conf0", 8'h20, 32'hFFFFFFFF, 32'h0800001C);
        rdw(8'h18);
        `CHK("unmapped", 2'b10, rr)
        look("idle status", 8'h1C, 32'hF000F700, 32'h00000700);
        $display("reset test done");
        wr(8'h40, 32'h0);
        wr(8'h58, 32'h0);
        wr(8'h14, 32'h4);
        wr(8'h20, 32'h0800001E);
        u_scp_line_partner.sendFrame(8'h55, 1'b0);
        look("rx count", 8'h1C, 32'hFF, 32'h1);
        look("edges", 8'h30, 32'h3FF, 32'd10);
        look("low pulse", 8'h28, 32'hFFFFF, 32'd8);
        look("high pulse", 8'h2C, 32'hFFFFF, 32'd8);
        look("rx byte", 8'h00, 32'hFF, 32'h55);
        u_scp_line_partner.sendFrame(8'h55, 1'b1);
        look("parity event", 8'h04, 32'h4, 32'h4);
        wr(8'h0C, 32'h0);
        look("masked off", 8'h08, 32'h4, 32'h0);
        wr(8'h0C, 32'h4);
        look("masked on", 8'h08, 32'h4, 32'h4);
        wr(8'h10, 32'h4);
        look("cleared", 8'h04, 32'h4, 32'h0);
        $display("receive test done");
        u_scp_line_partner.cts <= 1'b0;
        look("cts low", 8'h1C, 32'h200, 32'h0);
        wr(8'h20, 32'h0810001E);
        look("cts inverted", 8'h1C, 32'h200, 32'h200);
        wr(8'h20, 32'h0800009E);
        look("dtr status", 8'h1C, 32'h08000000, 32'h08000000);
        `CHK("dtr high", 1'b1, dtr)
        wr(8'h20, 32'h0900009E);
        look("dtr inverted", 8'h1C, 32'h08000000, 32'h0);
        `CHK("dtr low", 1'b0, dtr)
        wr(8'h20, 32'h0802001E);
        wr(8'h20, 32'h0800001E);
        look("rx flushed", 8'h1C, 32'hFF, 32'h0);
        $display("line test done");
        for (int k = 0; k < 4; k++) begin
            wr(8'h20, 32'h08004010 | (k << 2));
            wr(8'h00, 32'hFF);
            look("loop count", 8'h1C, 32'hFF, 32'h1);
            look("loop byte", 8'h00, 32'hFF, 32'hFF >> (3 - k));
        end
        wr(8'h24, 32'h00000100);
        look("events idle", 8'h04, 32'h3, 32'h2);
        wr(8'h00, 32'h5A);
        look("events full", 8'h04, 32'h3, 32'h3);
        wr(8'h24, 32'h0);
        look("tx not below", 8'h04, 32'h2, 32'h0);
        $display("loopback test done");
        wr(8'h20, 32'h0800001C);
        wr(8'h3C, 32'h13110000);
        for (int j = 0; j < 2; j++) begin
            wr(8'h34, 32'h10 << j);
            look("request cleared", 8'h34, 32'h30, 32'h0);
            look("sent event", 8'h04, 32'h40 << j, 32'h40 << j);
            look("tx idle", 8'h1C, 32'hF0000000, 32'h0);
            `CHK("flow char", (j == 0) ? 8'h11 : 8'h13, u_scp_line_partner.lastByte)
        end
        $display("flow test done");
        completeRun();
    end
endmodule
`default_nettype wire
